//--- hw/stcid_core.sv
// Instruction decoder for calls, timer 1, carrier and port operations
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "stcid_defs.svh"
module stcid_core (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [8:0]  instr_in,
  output logic      [9:0]  pc_out,
  input  wire logic        port_d7_in,
  output logic      [7:0]  port_d_out,
  output logic      [7:0]  port_d_oe_out,
  input  wire logic [2:0]  port_e_in,
  output logic      [1:0]  port_e_out,
  input  wire logic [3:0]  port_g_in,
  output logic      [3:0]  port_g_out,
  output logic      [3:0]  port_g_oe_out,
  input  wire logic        carrier_tick_in,
  input  wire logic        wdt_tick_in,
  input  wire logic        power_flag_in,
  input  wire logic        wake_in,
  output logic             carrier_out,
  output logic      [2:0]  timer_ctrl_out,
  output logic      [2:0]  carrier_sel_out,
  output logic      [1:0]  logic_sel_out,
  output logic      [2:0]  pulldown_out,
  output logic             upper_ref_out,
  output logic             clock_fast_out,
  output logic             backup_out,
  output logic             wdf_clear_out
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] ybit(input logic [3:0] y);
    ybit = (y[3] == 1'b0) ? (8'h01 << y[2:0]) : 8'h00;
  endfunction

  function automatic logic reg_known(input logic [7:0] ad);
    reg_known = (ad == `SC_ADDR_CTRL) || (ad == `SC_ADDR_ACC) ||
                (ad == `SC_ADDR_STAT) || (ad == `SC_ADDR_TMR);
  endfunction

  stcid_pkg::stcid_core_t core_r;
  stcid_pkg::stcid_core_t core_nxt;
  logic                   run_c;
  logic                   fire_c;
  logic                   t_ld_cnt;
  logic                   t_ld_rel;
  logic                   t_clr;
  logic                   t_tick;
  logic [7:0]             t_cnt;
  logic [7:0]             t_rel;
  logic                   t_flag;
  logic [9:0]             ret_c;
  logic [9:0]             top_c;
  logic                   acc_c;

  assign run_c = ce_in && core_r.run && !core_r.backup;
  assign fire_c = run_c && (core_r.st == stcid_pkg::st_exec) && !core_r.skip;
  assign ret_c = core_r.pc + 10'h001;
  assign top_c = core_r.stk[core_r.sp - 2'h1];
  assign acc_c = psel_in && penable_in;
  assign t_tick = core_r.v[1] ? wdt_tick_in : carrier_tick_in;

  // ---------------------------------------------------------------
  // Timer 1
  // ---------------------------------------------------------------
  stcid_timer u_timer (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .ce_in       (ce_in),
    .run_in      (core_r.v[0]),
    .tick_in     (t_tick),
    .ld_cnt_in   (t_ld_cnt),
    .ld_rel_in   (t_ld_rel),
    .clr_in      (t_clr),
    .data_in     ({core_r.b, core_r.a}),
    .cnt_out     (t_cnt),
    .rel_out     (t_rel),
    .flag_out    (t_flag)
  );

  // ---------------------------------------------------------------
  // Execution and register access
  // ---------------------------------------------------------------
  always_comb begin
    core_nxt = core_r;
    t_ld_cnt = 1'b0;
    t_ld_rel = 1'b0;
    t_clr = 1'b0;
    core_nxt.wdf_clr = 1'b0;
    core_nxt.pready = 1'b0;
    if (core_r.backup && wake_in) begin
      core_nxt.backup = 1'b0;
    end
    if (run_c) begin
      core_nxt.pc = ret_c;
      case (core_r.st)
        stcid_pkg::st_exec: begin
          if (core_r.skip) begin
            core_nxt.skip = 1'b0;
          end else if (instr_in[8:7] == 2'b10) begin
            core_nxt.stk[core_r.sp] = ret_c;
            core_nxt.sp = core_r.sp + 2'h1;
            core_nxt.pc = {`SC_PAGE_TWO, instr_in[6:0]};
          end else begin
            core_nxt.op = instr_in;
            case (instr_in)
              `SC_OP_CALL_IDX, `SC_OP_TST_D: begin
                core_nxt.st = stcid_pkg::st_oper;
              end
              `SC_OP_RET, `SC_OP_RETS: begin
                core_nxt.st = stcid_pkg::st_ret;
              end
              `SC_OP_RD_T: begin
                core_nxt.b = t_cnt[7:4];
                core_nxt.a = t_cnt[3:0];
              end
              `SC_OP_WR_T: begin
                t_ld_rel = 1'b1;
                t_ld_cnt = !core_r.v[0];
              end
              `SC_OP_WR_V: begin
                core_nxt.v = core_r.a[2:0];
              end
              `SC_OP_TST_T: begin
                core_nxt.skip = t_flag;
                t_clr = t_flag;
              end
              `SC_OP_C_FROM_A: begin
                core_nxt.c = core_r.a[2:0];
              end
              `SC_OP_C_TO_A: begin
                core_nxt.a[2:0] = core_r.c;
                core_nxt.carr = 1'b0;
              end
              `SC_OP_WR_CARR: begin
                core_nxt.carr = core_r.a[3];
              end
              `SC_OP_CLR_D: begin
                core_nxt.d = 8'h00;
              end
              `SC_OP_RST_D: begin
                core_nxt.d = core_r.d & ~ybit(core_r.y);
              end
              `SC_OP_SET_D: begin
                core_nxt.d = core_r.d | ybit(core_r.y);
              end
              `SC_OP_WR_E: begin
                core_nxt.e = core_r.a[1:0];
              end
              `SC_OP_RD_E: begin
                core_nxt.a = {1'b0, port_e_in};
              end
              `SC_OP_WR_G: begin
                core_nxt.g = core_r.a;
              end
              `SC_OP_RD_G: begin
                core_nxt.a = port_g_in;
              end
              `SC_OP_BACKUP: begin
                core_nxt.backup = 1'b1;
              end
              `SC_OP_TST_P: begin
                core_nxt.skip = power_flag_in;
              end
              `SC_OP_CLK_SW: begin
                core_nxt.fast = 1'b1;
              end
              `SC_OP_WR_LO: begin
                core_nxt.lo = core_r.a[1:0];
              end
              `SC_OP_URS: begin
                core_nxt.upper_ref_enable = 1'b1;
              end
              `SC_OP_WR_PU: begin
                core_nxt.pu = core_r.a[2:0];
              end
              `SC_OP_WDF_CLR: begin
                core_nxt.wdf_clr = 1'b1;
              end
              default: begin
                if (instr_in[8:4] == `SC_OP_CALL_L) begin
                  core_nxt.st = stcid_pkg::st_oper;
                end
              end
            endcase
          end
        end
        stcid_pkg::st_oper: begin
          core_nxt.st = stcid_pkg::st_exec;
          if (core_r.op == `SC_OP_TST_D) begin
            core_nxt.skip = (instr_in == `SC_OP_TST_D2) && (core_r.y == `SC_Y_TEST) &&
                            !port_d7_in;
          end else if (core_r.op == `SC_OP_CALL_IDX) begin
            core_nxt.stk[core_r.sp] = ret_c;
            core_nxt.sp = core_r.sp + 2'h1;
            core_nxt.pc = {instr_in[2:0], instr_in[6:4], core_r.a};
          end else begin
            core_nxt.stk[core_r.sp] = ret_c;
            core_nxt.sp = core_r.sp + 2'h1;
            core_nxt.pc = {core_r.op[2:0], instr_in[6:0]};
          end
        end
        stcid_pkg::st_ret: begin
          core_nxt.st = stcid_pkg::st_exec;
          core_nxt.pc = top_c;
          core_nxt.sp = core_r.sp - 2'h1;
          core_nxt.skip = core_r.op[0];
        end
        default: begin
          core_nxt.st = stcid_pkg::st_exec;
        end
      endcase
    end
    if (acc_c && !core_r.pready) begin
      core_nxt.pready = 1'b1;
      core_nxt.pslverr = !reg_known(paddr_in);
      case (paddr_in)
        `SC_ADDR_CTRL: core_nxt.prdata = {31'h0, core_r.run};
        `SC_ADDR_ACC:  core_nxt.prdata = {20'h0, core_r.y, core_r.b, core_r.a};
        `SC_ADDR_STAT: core_nxt.prdata = {5'h0, core_r.st, core_r.d, core_r.carr, core_r.fast,
                                          core_r.backup, core_r.skip, core_r.sp, core_r.pc};
        `SC_ADDR_TMR:  core_nxt.prdata = {9'h0, core_r.c, t_flag, core_r.v, t_rel, t_cnt};
        default:       core_nxt.prdata = 32'h0;
      endcase
    end
    if (acc_c && core_r.pready && pwrite_in) begin
      if (paddr_in == `SC_ADDR_CTRL) begin
        core_nxt.run = pwdata_in[0];
      end else if (paddr_in == `SC_ADDR_ACC) begin
        core_nxt.a = pwdata_in[3:0];
        core_nxt.b = pwdata_in[7:4];
        core_nxt.y = pwdata_in[11:8];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_r <= '0;
      core_r.st <= stcid_pkg::st_exec;
      core_r.v <= `SC_RST_V;
      core_r.c <= `SC_RST_C;
      core_r.lo <= `SC_RST_LO;
      core_r.pu <= `SC_RST_PU;
    end else if (ce_in) begin
      core_r <= core_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata_out = core_r.prdata;
  assign pready_out = core_r.pready;
  assign pslverr_out = core_r.pslverr;
  assign pc_out = core_r.pc;
  assign port_d_out = core_r.d;
  assign port_d_oe_out = core_r.d;
  assign port_e_out = core_r.e;
  assign port_g_out = core_r.g;
  assign port_g_oe_out = core_r.g;
  assign carrier_out = core_r.carr;
  assign timer_ctrl_out = core_r.v;
  assign carrier_sel_out = core_r.c;
  assign logic_sel_out = core_r.lo;
  assign pulldown_out = core_r.pu;
  assign upper_ref_out = core_r.upper_ref_enable;
  assign clock_fast_out = core_r.fast;
  assign backup_out = core_r.backup;
  assign wdf_clear_out = core_r.wdf_clr;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_call_page_two: assert property (fire_c && instr_in[8:7] == 2'b10 |=>
    pc_out == {`SC_PAGE_TWO, $past(instr_in[6:0])} && core_r.sp == $past(core_r.sp) + 2'h1)
    else $error("short call target wrong");
  a_call_long_pc: assert property (fire_c && instr_in[8:4] == `SC_OP_CALL_L ##1
    run_c && instr_in[8:7] == 2'b10 |=> pc_out == {$past(core_r.op[2:0]), $past(instr_in[6:0])})
    else $error("long call target wrong");
  a_call_indexed: assert property (run_c && core_r.st == stcid_pkg::st_oper &&
    core_r.op == `SC_OP_CALL_IDX |=> pc_out[3:0] == $past(core_r.a))
    else $error("indexed call low bits wrong");
  a_return_pop: assert property (run_c && core_r.st == stcid_pkg::st_ret |=>
    pc_out == $past(top_c) && core_r.skip == $past(core_r.op[0]))
    else $error("return did not restore pc");
  a_timer_read: assert property (fire_c && instr_in == `SC_OP_RD_T |=>
    {core_r.b, core_r.a} == $past(t_cnt))
    else $error("timer read wrong");
  a_timer_write: assert property (fire_c && instr_in == `SC_OP_WR_T |->
    t_ld_rel && t_ld_cnt == !core_r.v[0])
    else $error("timer write load wrong");
  a_timer_ctrl: assert property (fire_c && instr_in == `SC_OP_WR_V |=>
    timer_ctrl_out == $past(core_r.a[2:0]))
    else $error("timer control not written");
  a_flag_skip: assert property (fire_c && instr_in == `SC_OP_TST_T |=>
    core_r.skip == $past(t_flag))
    else $error("timer flag skip wrong");
  a_carrier_read: assert property (fire_c && instr_in == `SC_OP_C_TO_A |=>
    !carrier_out && core_r.a == {$past(core_r.a[3]), $past(core_r.c)})
    else $error("carrier read wrong");
  a_port_d_set: assert property (fire_c && instr_in == `SC_OP_SET_D && !core_r.y[3] |=>
    port_d_out[$past(core_r.y[2:0])])
    else $error("port d bit not set");

  c_call_long: cover property (fire_c && instr_in[8:4] == `SC_OP_CALL_L);
  c_return_skip: cover property (run_c && core_r.st == stcid_pkg::st_ret && core_r.op[0]);
  c_flag_skip: cover property (fire_c && instr_in == `SC_OP_TST_T && t_flag);
endmodule // stcid_core
`default_nettype wire

//--- hw/stcid_defs.svh
// Opcode, register offset and reset constants for the instruction decoder
`ifndef STCID_DEFS_SVH
`define STCID_DEFS_SVH
// -----------------------------------------------------------------
// Opcodes, short call page and port D test Y value
// -----------------------------------------------------------------
`define SC_OP_CALL_L    5'h07
`define SC_OP_CALL_IDX  9'h050
`define SC_OP_RET       9'h044
`define SC_OP_RETS      9'h045
`define SC_OP_RD_T      9'h057
`define SC_OP_WR_T      9'h047
`define SC_OP_WR_V      9'h05b
`define SC_OP_TST_T     9'h042
`define SC_OP_C_FROM_A  9'h040
`define SC_OP_C_TO_A    9'h05a
`define SC_OP_WR_CARR   9'h086
`define SC_OP_CLR_D     9'h011
`define SC_OP_RST_D     9'h014
`define SC_OP_SET_D     9'h015
`define SC_OP_TST_D     9'h024
`define SC_OP_TST_D2    9'h02b
`define SC_OP_WR_E      9'h084
`define SC_OP_RD_E      9'h056
`define SC_OP_WR_G      9'h080
`define SC_OP_RD_G      9'h028
`define SC_OP_NOP       9'h000
`define SC_OP_BACKUP    9'h00d
`define SC_OP_TST_P     9'h003
`define SC_OP_CLK_SW    9'h059
`define SC_OP_WR_LO     9'h058
`define SC_OP_URS       9'h082
`define SC_OP_WR_PU     9'h08f
`define SC_OP_WDF_CLR   9'h00f
`define SC_PAGE_TWO     3'h2
`define SC_Y_TEST       4'h7
// -----------------------------------------------------------------
// Register offsets and reset values
// -----------------------------------------------------------------
`define SC_ADDR_CTRL    8'h00
`define SC_ADDR_ACC     8'h04
`define SC_ADDR_STAT    8'h08
`define SC_ADDR_TMR     8'h0c
`define SC_RST_V        3'h0
`define SC_RST_C        3'h7
`define SC_RST_LO       2'h0
`define SC_RST_PU       3'h0
`endif

//--- hw/stcid_pkg.sv
// Types for the instruction decoder
package stcid_pkg;
  typedef enum logic [2:0] {
    st_exec = 3'b001,
    st_oper = 3'b010,
    st_ret  = 3'b100
  } stcid_state_t;

  typedef struct packed {
    stcid_state_t    st;
    logic            skip;
    logic [9:0]      pc;
    logic [1:0]      sp;
    logic [3:0][9:0] stk;
    logic [8:0]      op;
    logic [3:0]      a;
    logic [3:0]      b;
    logic [3:0]      y;
    logic [2:0]      v;
    logic [2:0]      c;
    logic            carr;
    logic [7:0]      d;
    logic [1:0]      e;
    logic [3:0]      g;
    logic [1:0]      lo;
    logic [2:0]      pu;
    logic            upper_ref_enable;
    logic            fast;
    logic            backup;
    logic            wdf_clr;
    logic            run;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } stcid_core_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] rel;
    logic       flag;
  } stcid_timer_t;
endpackage

//--- hw/stcid_timer.sv
// Timer 1 counter, reload register and underflow flag
`timescale 1ns/10ps
`default_nettype none
module stcid_timer (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       run_in,
  input  wire logic       tick_in,
  input  wire logic       ld_cnt_in,
  input  wire logic       ld_rel_in,
  input  wire logic       clr_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] cnt_out,
  output logic      [7:0] rel_out,
  output logic            flag_out
);
  stcid_pkg::stcid_timer_t tmr_r;
  stcid_pkg::stcid_timer_t tmr_nxt;

  always_comb begin
    tmr_nxt = tmr_r;
    if (clr_in) begin
      tmr_nxt.flag = 1'b0;
    end
    if (ld_rel_in) begin
      tmr_nxt.rel = data_in;
    end
    if (run_in && tick_in) begin
      if (tmr_r.cnt == 8'h00) begin
        tmr_nxt.cnt = tmr_r.rel;
        tmr_nxt.flag = 1'b1;
      end else begin
        tmr_nxt.cnt = tmr_r.cnt - 8'h01;
      end
    end
    if (ld_cnt_in) begin
      tmr_nxt.cnt = data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tmr_r <= '0;
    end else if (ce_in) begin
      tmr_r <= tmr_nxt;
    end
  end

  assign cnt_out = tmr_r.cnt;
  assign rel_out = tmr_r.rel;
  assign flag_out = tmr_r.flag;
endmodule // stcid_timer
`default_nettype wire

//--- bench/stcid_rom.sv
// Program memory model for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
module stcid_rom (
  input  wire logic [9:0] addr_in,
  output logic      [8:0] data_out
);
  logic [8:0] mem [0:1023];
  // ------------------------------------------------
  // Read port, same cycle as the address
  // ------------------------------------------------
  assign data_out = mem[addr_in];
endmodule // stcid_rom
`default_nettype wire

//--- bench/tb.sv
// Self-checking testbench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        core_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [2:0]  port_e_in = 3'h0;
  logic [3:0]  g_drv = 4'h0;
  logic        carrier_tick_in = 1'b0;
  logic        wdt_tick_in = 1'b0;
  logic        power_flag_in = 1'b0;
  logic        wake_in = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, port_d7_in, carrier_out;
  logic        upper_ref_out, clock_fast_out, backup_out, wdf_clear_out;
  logic [8:0]  instr_in;
  logic [9:0]  pc_out;
  logic [7:0]  port_d_out, port_d_oe_out;
  logic [1:0]  port_e_out, logic_sel_out;
  logic [3:0]  port_g_in, port_g_out, port_g_oe_out;
  logic [2:0]  timer_ctrl_out, carrier_sel_out, pulldown_out;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n_wdf = 0;
  // ------------------------------------------------
  // Pins, design and program memory
  // ------------------------------------------------
  assign port_d7_in = port_d_oe_out[7] & port_d_out[7];
  assign port_g_in = (port_g_oe_out & port_g_out) | (~port_g_oe_out & g_drv);
  stcid_core stcid_core_i (.core_clk_in, .rst_n_in, .ce_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .instr_in, .pc_out, .port_d7_in, .port_d_out, .port_d_oe_out, .port_e_in,
    .port_e_out, .port_g_in, .port_g_out, .port_g_oe_out, .carrier_tick_in,
    .wdt_tick_in, .power_flag_in, .wake_in, .carrier_out, .timer_ctrl_out,
    .carrier_sel_out, .logic_sel_out, .pulldown_out, .upper_ref_out,
    .clock_fast_out, .backup_out, .wdf_clear_out);
  stcid_rom stcid_rom_i (.addr_in(pc_out), .data_out(instr_in));
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (wdf_clear_out === 1'b1) n_wdf <= n_wdf + 1;
    if (cyc == 30000) begin
      n_errors++;
      complete_run();
    end
  end
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge core_clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(n, e, rd);
  endtask
  task automatic load(input logic [8:0] q[$]);
    for (int i = 0; i < 1024; i++) stcid_rom_i.mem[i] = 9'h000;
    stcid_rom_i.mem[10'h17f] = 9'h17f;
    foreach (q[j]) stcid_rom_i.mem[j] = q[j];
  endtask
  task automatic go(input logic [11:0] acc);
    rst_n_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    wr(8'h04, {20'h0, acc});
    wr(8'h00, 32'h1);
  endtask
  task automatic halt;
    for (int i = 0; i < 300 && pc_out !== 10'h17f; i++) @(posedge core_clk_in);
    chk("pc", 10'h17f, pc_out);
    wr(8'h00, 32'h0);
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [31:0] s0;
    logic er;
    logic [3:0] a0, b0, g;
    logic [2:0] e, y;
    logic p;
    logic [8:0] q[$];
    void'($urandom(32'hfa7a));
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    chk("sel_rst", 3'h7, carrier_sel_out);
    rd_chk("tmr_rst", 8'h0c, 32'h0070_0000);
    rd_chk("acc_rst", 8'h04, 32'h0);
    apb(1'b0, 8'h08, 32'h0, s0, er);
    wr(8'h08, 32'hffff_ffff);
    rd_chk("stat_ro", 8'h08, s0);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk("slverr", 1'b1, er);
    chk("err_data", 32'h0, rd);
    // Calls and returns
    q = '{9'h071, 9'h105, 9'h082, 9'h050, 9'h132, 9'h080, 9'h086, 9'h17f};
    load(q);
    stcid_rom_i.mem[10'h085] = 9'h045;
    stcid_rom_i.mem[10'h13a] = 9'h044;
    go(12'h00a);
    halt();
    chk("g_call", 4'ha, port_g_out);
    chk("skip_ret", 1'b0, upper_ref_out);
    chk("carr_a3", 1'b1, carrier_out);
    // Timer transfers
    a0 = 4'($urandom);
    b0 = 4'($urandom);
    g = ~a0 | 4'h1;
    g_drv <= g;
    q = '{9'h047, 9'h028, 9'h05b, 9'h047, 9'h057, 9'h17f};
    load(q);
    go({4'h0, b0, a0});
    halt();
    chk("tctrl", g[2:0], timer_ctrl_out);
    rd_chk("tmr", 8'h0c, {9'h0, 3'h7, 1'b0, g[2:0], b0, g, b0, a0});
    rd_chk("acc_t", 8'h04, {24'h0, b0, a0});
    // Underflow flag skip and clear
    e = 3'($urandom) & 3'h6;
    port_e_in <= e;
    g_drv <= 4'h1;
    carrier_tick_in <= 1'b1;
    q = '{9'h028, 9'h05b, 9'h056, 9'h05b, 9'h042, 9'h059, 9'h042, 9'h082, 9'h17f};
    load(q);
    go(12'h000);
    halt();
    carrier_tick_in <= 1'b0;
    chk("flag_skip", 1'b0, clock_fast_out);
    chk("flag_noskip", 1'b1, upper_ref_out);
    rd_chk("tmr_f", 8'h0c, {9'h0, 3'h7, 1'b0, e, 16'h0});
    // Carrier, ports and selections
    g = {1'b1, 3'(3 + $urandom % 3)};
    y = 3'($urandom);
    g_drv <= g;
    q = '{9'h059, 9'h086, 9'h040, 9'h015, 9'h08f, 9'h058, 9'h084, 9'h028, 9'h080, 9'h05a, 9'h17f};
    load(q);
    go({1'b0, y, 8'h0a});
    halt();
    chk("fast", 1'b1, clock_fast_out);
    chk("csel", 3'h2, carrier_sel_out);
    chk("carr_clr", 1'b0, carrier_out);
    chk("d_set", 8'h01 << y, port_d_out);
    chk("pulldown", 3'h2, pulldown_out);
    chk("lsel", 2'h2, logic_sel_out);
    chk("e_out", 2'h2, port_e_out);
    chk("g_out", g, port_g_out);
    chk("g_oe", g, port_g_oe_out);
    chk("d_oe", 8'h01 << y, port_d_oe_out);
    rd_chk("acc_c", 8'h04, {20'h0, 1'b0, y, 4'h0, g[3], 3'h2});
    // Port D bit test over Y values 0 to 7
    q = '{9'h024, 9'h02b, 9'h082, 9'h015, 9'h024, 9'h02b, 9'h084, 9'h014, 9'h17f};
    load(q);
    for (int k = 0; k < 8; k++) begin
      go({1'b0, 3'(k), 8'h01});
      halt();
      chk("d7_low", 1'(k != 7), upper_ref_out);
      chk("d7_high", 2'h1, port_e_out);
      chk("d_rst", 8'h00, port_d_out);
    end
    // Power flag, watchdog clear and back-up
    p = 1'($urandom);
    power_flag_in <= p;
    n_wdf = 0;
    q = '{9'h003, 9'h082, 9'h00f, 9'h00d, 9'h080, 9'h17f};
    load(q);
    go(12'h005);
    for (int i = 0; i < 100 && backup_out !== 1'b1; i++) @(posedge core_clk_in);
    apb(1'b0, 8'h08, 32'h0, rd, er);
    chk("backup", 1'b1, rd[13]);
    chk("g_halt", 4'h0, port_g_out);
    wake_in <= 1'b1;
    for (int i = 0; i < 100 && backup_out !== 1'b0; i++) @(posedge core_clk_in);
    wake_in <= 1'b0;
    halt();
    chk("g_wake", 4'h5, port_g_out);
    chk("pflag", !p, upper_ref_out);
    chk("wdf", 32'h1, 32'(n_wdf));
    complete_run();
  end
endmodule // tb
`default_nettype wire
